//--- design/ltlog_top.sv
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module ltlog_top
	import ltlog_pkg::*;
#(
	parameter longint POLL_CYCLES_P = POLL_CYCLES // Shorten for simulation
) (
	input wire logic clk, // 25 MHz clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte lanes
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire ltlog_reading_type reading, // Front end reading, same clock
	input wire logic reading_valid, // One-cycle pulse, new reading
	input wire logic [5:0] protector_status, // Protector fault pins
	output logic store_request, // Pulse: records written to storage
	output logic irq // Level interrupt
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Signed difference a-b compared against an unsigned step
	// Eighteen bits hold the widest swing of two 16-bit values plus a sign,
	// so a reading near one end never wraps past a record at the other
	function automatic logic beats_by_step(input logic [15:0] a, input logic [15:0] b,
			input logic [7:0] step);
		logic signed [17:0] diff;
		diff = 18'($signed(a)) - 18'($signed(b));
		// Step widened with zeros: it stays unsigned however large
		return diff > $signed({10'h000, step});
	endfunction : beats_by_step

	// Plain signed order, used when another record drags this one along
	function automatic logic beats(input logic [15:0] a, input logic [15:0] b);
		return $signed(a) > $signed(b);
	endfunction : beats

	// True when the held write request targets the given byte address
	function automatic logic write_hit(input logic wr, input logic [7:0] adr,
			input logic [7:0] target);
		return wr && (adr == target);
	endfunction : write_hit

	// Merge a Wishbone write into a 16-bit register by byte lanes
	// Lanes 2 and 3 are ignored; every register fits in the low half word
	function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] sel);
		return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction : lane16

	// ----------------------------------------------------------------
	// Input synchronisers and registers
	// ----------------------------------------------------------------
	// Synchroniser stages
	logic [5:0] prot_meta;
	logic [5:0] prot_sync;

	// Records and software registers
	ltlog_records_type rec;
	logic [7:0] temperature_step;
	logic [7:0] voltage_step;
	logic [7:0] current_step;
	logic [15:0] log_write_counter;
	logic [7:0] cumulative_fault_byte;
	logic gauging_enabled_bit;

	// Interrupt status and mask
	logic [IRQ_WIDTH-1:0] irq_status;
	logic [IRQ_WIDTH-1:0] irq_enable;

	// Sequencer, timebase and throttle
	ltlog_state_type state;
	ltlog_reading_type sample;
	logic [31:0] poll_count;
	logic poll_tick;
	logic [5:0] store_wait;
	logic store_allowed;

	// Per-record decisions, bit order as in the record struct
	logic [5:0] want;
	logic [5:0] merely;
	logic [5:0] upd;

	// Bus and interrupt decode
	logic bus_req;
	logic bus_write;
	logic [IRQ_WIDTH-1:0] irq_set;
	logic [IRQ_WIDTH-1:0] irq_clear;
	logic [7:0] new_faults;

	// Protector pins are asynchronous; two flops before use
	// The first stage may be metastable, so only the second flop reads it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prot_meta <= 6'h00;
			prot_sync <= 6'h00;
		end else begin
			prot_meta <= protector_status;
			prot_sync <= prot_meta;
		end
	end

	// ----------------------------------------------------------------
	// Timebase: one-second poll tick and store throttle
	// ----------------------------------------------------------------
	// Free-running divider; the tick is a one-cycle enable, not a clock
	// Ticks are not aligned to stores, so a throttle span may be a tick short
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			poll_count <= 32'h00000000;
			poll_tick <= 1'b0;
		end else if (poll_count >= 32'(POLL_CYCLES_P - 1)) begin
			poll_count <= 32'h00000000;
			poll_tick <= 1'b1;
		end else begin
			poll_count <= poll_count + 32'h00000001;
			poll_tick <= 1'b0;
		end
	end

	// Seconds left until the next store is allowed; first store is allowed right after reset
	// Readings are refused while it counts, so storage sees no extra wear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			store_wait <= 6'h00;
		end else if (state == ST_STORE) begin
			store_wait <= 6'(STORE_INTERVAL_S);
		end else if (poll_tick && store_wait != 6'h00) begin
			store_wait <= store_wait - 6'h01;
		end
	end
	assign store_allowed = (store_wait == 6'h00);

	// ----------------------------------------------------------------
	// Update decisions, all six records judged on one sample
	// ----------------------------------------------------------------
	// Voltage is compared signed too; its range stops at 32767, so the sign
	// bit never sets and the result matches an unsigned compare
	always_comb begin
		// Step-qualified: the difference must exceed the step, equal is not enough
		want[0] = beats_by_step(sample.temperature, rec.temp_high, temperature_step);
		want[1] = beats_by_step(rec.temp_low, sample.temperature, temperature_step);
		want[2] = beats_by_step(sample.voltage, rec.volt_high, voltage_step);
		want[3] = beats_by_step(rec.volt_low, sample.voltage, voltage_step);
		want[4] = beats_by_step(sample.current, rec.chg_peak, current_step);
		want[5] = beats_by_step(rec.dsg_peak, sample.current, current_step);
		// Merely better: no step needed, used only when some record qualifies
		merely[0] = beats(sample.temperature, rec.temp_high);
		merely[1] = beats(rec.temp_low, sample.temperature);
		merely[2] = beats(sample.voltage, rec.volt_high);
		merely[3] = beats(rec.volt_low, sample.voltage);
		merely[4] = beats(sample.current, rec.chg_peak);
		merely[5] = beats(rec.dsg_peak, sample.current);
		// Any step-qualified record drags the merely-better ones along
		upd = want | (merely & {6{|want}});
	end

	// ----------------------------------------------------------------
	// Sequencer: wait for reading, evaluate, store
	// ----------------------------------------------------------------
	// IDLE takes one reading, EVAL commits the records, STORE counts the
	// write and starts the throttle; a pass without a qualifying record
	// goes back to IDLE and leaves storage untouched
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			sample <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					// Gate on enable and throttle; readings in between are dropped
					// A reading that arrives in EVAL or STORE is not queued
					if (reading_valid && gauging_enabled_bit && store_allowed) begin
						sample <= reading;
						state <= ST_EVAL;
					end
				end
				ST_EVAL: begin
					// Records change on this edge when any step qualifies
					state <= (|want) ? ST_STORE : ST_IDLE;
				end
				ST_STORE: begin
					// One cycle only; counter, throttle and interrupt all key on it
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Registered copy of the store state so the pin comes from a flop;
	// it lags the store state by one cycle and rises on the same edge as the counter update
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			store_request <= 1'b0;
		end else begin
			store_request <= (state == ST_STORE);
		end
	end

	// ----------------------------------------------------------------
	// Wishbone decode
	// ----------------------------------------------------------------
	// A request is taken once; ack low gates it so the held request
	// is not taken a second time in the ack cycle
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_write = bus_req && wb_we_i;

	// Records: hardware update in EVAL beats a software write
	// A write in that cycle is lost; the lifetime value wins because it
	// reflects what the pack really saw
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rec.temp_high <= RST_TEMP_HIGH;
			rec.temp_low <= RST_TEMP_LOW;
			rec.volt_high <= RST_VOLT_HIGH;
			rec.volt_low <= RST_VOLT_LOW;
			rec.chg_peak <= RST_CHG_PEAK;
			rec.dsg_peak <= RST_DSG_PEAK;
		end else if (state == ST_EVAL && |want) begin
			if (upd[0]) rec.temp_high <= sample.temperature;
			if (upd[1]) rec.temp_low <= sample.temperature;
			if (upd[2]) rec.volt_high <= sample.voltage;
			if (upd[3]) rec.volt_low <= sample.voltage;
			if (upd[4]) rec.chg_peak <= sample.current;
			if (upd[5]) rec.dsg_peak <= sample.current;
		end else if (bus_write) begin
			case (wb_adr_i)
				ADDR_TEMP_HIGH: rec.temp_high <= lane16(rec.temp_high, wb_dat_i, wb_sel_i);
				ADDR_TEMP_LOW: rec.temp_low <= lane16(rec.temp_low, wb_dat_i, wb_sel_i);
				ADDR_VOLT_HIGH: rec.volt_high <= lane16(rec.volt_high, wb_dat_i, wb_sel_i);
				ADDR_VOLT_LOW: rec.volt_low <= lane16(rec.volt_low, wb_dat_i, wb_sel_i);
				ADDR_CHG_PEAK: rec.chg_peak <= lane16(rec.chg_peak, wb_dat_i, wb_sel_i);
				ADDR_DSG_PEAK: rec.dsg_peak <= lane16(rec.dsg_peak, wb_dat_i, wb_sel_i);
				default: begin
				end
			endcase
		end
	end

	// Steps and control
	// Byte registers use lane 0 only; the upper lanes are ignored
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			temperature_step <= RST_TEMP_STEP;
			voltage_step <= RST_VOLT_STEP;
			current_step <= RST_CUR_STEP;
			gauging_enabled_bit <= 1'b0;
			irq_enable <= '0;
		end else if (bus_write && wb_sel_i[0]) begin
			case (wb_adr_i)
				ADDR_TEMP_STEP: temperature_step <= wb_dat_i[7:0];
				ADDR_VOLT_STEP: voltage_step <= wb_dat_i[7:0];
				ADDR_CUR_STEP: current_step <= wb_dat_i[7:0];
				ADDR_CONTROL: gauging_enabled_bit <= wb_dat_i[CTRL_GAUGING_ENABLED];
				ADDR_IRQ_ENABLE: irq_enable <= wb_dat_i[IRQ_WIDTH-1:0];
				default: begin
				end
			endcase
		end
	end

	// Write counter saturates at its top; software may preset it
	// Bit 15 stays clear so the count never leaves its 0..32767 range
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			log_write_counter <= RST_WRITE_CNT;
		end else if (state == ST_STORE) begin
			// Saturate rather than wrap, so a worn log still reads full
			if (log_write_counter[14:0] != WRITE_CNT_MAX) begin
				log_write_counter <= {1'b0, log_write_counter[14:0] + 15'h0001};
			end
		end else if (write_hit(bus_write, wb_adr_i, ADDR_WRITE_CNT)) begin
			log_write_counter <= {1'b0, 15'(lane16(log_write_counter, wb_dat_i, wb_sel_i))};
		end
	end

	// Fault byte: poll once a second, OR in; new events win over a write
	// Only unseen events count as new, so the new-fault interrupt fires
	// once per event rather than once per poll
	assign new_faults = {2'b00, prot_sync} & ~cumulative_fault_byte & FAULT_MASK;
	// Reserved bits 7:6 are forced to zero on every path
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cumulative_fault_byte <= RST_FAULT;
		end else begin
			if (write_hit(bus_write, wb_adr_i, ADDR_FAULT) && wb_sel_i[0]) begin
				cumulative_fault_byte <= (wb_dat_i[7:0] & FAULT_MASK)
					| (poll_tick ? new_faults : 8'h00);
			end else if (poll_tick) begin
				cumulative_fault_byte <= cumulative_fault_byte | new_faults;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts: sticky status, write-one-to-clear, set wins
	// ----------------------------------------------------------------
	// Store and new-fault events set; a written one clears
	assign irq_set[IRQ_RECORD_WRITE] = (state == ST_STORE);
	assign irq_set[IRQ_NEW_FAULT] = poll_tick && (|new_faults);
	assign irq_clear = (write_hit(bus_write, wb_adr_i, ADDR_IRQ_CLEAR) && wb_sel_i[0])
		? wb_dat_i[IRQ_WIDTH-1:0] : '0;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_status <= '0;
			irq <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_set;
			// Level follows the next status, so it never lags it by a cycle
			irq <= |(((irq_status & ~irq_clear) | irq_set) & irq_enable);
		end
	end

	// ----------------------------------------------------------------
	// Read mux and acknowledge, one wait-free cycle
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			// Data stands only in the ack cycle and reads zero otherwise, so a
			// late sampler sees zero rather than stale data
			if (bus_req && !wb_we_i) begin
				// Unused upper bits read zero
				case (wb_adr_i)
					ADDR_TEMP_HIGH: wb_dat_o <= {16'h0000, rec.temp_high};
					ADDR_TEMP_LOW: wb_dat_o <= {16'h0000, rec.temp_low};
					ADDR_VOLT_HIGH: wb_dat_o <= {16'h0000, rec.volt_high};
					ADDR_VOLT_LOW: wb_dat_o <= {16'h0000, rec.volt_low};
					ADDR_CHG_PEAK: wb_dat_o <= {16'h0000, rec.chg_peak};
					ADDR_DSG_PEAK: wb_dat_o <= {16'h0000, rec.dsg_peak};
					ADDR_TEMP_STEP: wb_dat_o <= {24'h000000, temperature_step};
					ADDR_VOLT_STEP: wb_dat_o <= {24'h000000, voltage_step};
					ADDR_CUR_STEP: wb_dat_o <= {24'h000000, current_step};
					ADDR_WRITE_CNT: wb_dat_o <= {16'h0000, log_write_counter};
					ADDR_FAULT: wb_dat_o <= {24'h000000, cumulative_fault_byte};
					ADDR_CONTROL: wb_dat_o <= {31'h00000000, gauging_enabled_bit};
					ADDR_IRQ_STATUS: wb_dat_o <= {30'h00000000, irq_status};
					ADDR_IRQ_ENABLE: wb_dat_o <= {30'h00000000, irq_enable};
					default: wb_dat_o <= 32'h00000000; // Unmapped and clear reg read 0
				endcase
			end else begin
				wb_dat_o <= 32'h00000000;
			end
		end
	end

endmodule : ltlog_top

//--- design/ltlog_pkg.sv
package ltlog_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_TEMP_HIGH = 8'h00;
	localparam logic [7:0] ADDR_TEMP_LOW = 8'h04;
	localparam logic [7:0] ADDR_VOLT_HIGH = 8'h08;
	localparam logic [7:0] ADDR_VOLT_LOW = 8'h0C;
	localparam logic [7:0] ADDR_CHG_PEAK = 8'h10;
	localparam logic [7:0] ADDR_DSG_PEAK = 8'h14;
	localparam logic [7:0] ADDR_TEMP_STEP = 8'h18;
	localparam logic [7:0] ADDR_VOLT_STEP = 8'h1C;
	localparam logic [7:0] ADDR_CUR_STEP = 8'h20;
	localparam logic [7:0] ADDR_WRITE_CNT = 8'h24;
	localparam logic [7:0] ADDR_FAULT = 8'h28;
	localparam logic [7:0] ADDR_CONTROL = 8'h2C;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h34;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h38;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_TEMP_HIGH = 16'h0000;
	localparam logic [15:0] RST_TEMP_LOW = 16'h01F4;
	localparam logic [15:0] RST_VOLT_HIGH = 16'h0AF0;
	localparam logic [15:0] RST_VOLT_LOW = 16'h1388;
	localparam logic [15:0] RST_CHG_PEAK = 16'h0000;
	localparam logic [15:0] RST_DSG_PEAK = 16'h0000;
	localparam logic [7:0] RST_TEMP_STEP = 8'h0A;
	localparam logic [7:0] RST_VOLT_STEP = 8'h19;
	localparam logic [7:0] RST_CUR_STEP = 8'h64;
	localparam logic [15:0] RST_WRITE_CNT = 16'h0000;
	localparam logic [7:0] RST_FAULT = 8'h00;
	localparam logic [14:0] WRITE_CNT_MAX = 15'h7FFF;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FAULT_CELL_MONITOR = 5;
	localparam int FAULT_UNDERVOLTAGE = 4;
	localparam int FAULT_OVERVOLTAGE = 3;
	localparam int FAULT_SHORT_DSG = 2;
	localparam int FAULT_OVERCUR_DSG = 1;
	localparam int FAULT_OVERCUR_CHG = 0;
	localparam logic [7:0] FAULT_MASK = 8'h3F;
	localparam int CTRL_GAUGING_ENABLED = 0;
	localparam int IRQ_RECORD_WRITE = 0;
	localparam int IRQ_NEW_FAULT = 1;
	localparam int IRQ_WIDTH = 2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam longint CLOCK_HZ = 25000000;
	localparam longint POLL_PERIOD_MS = 1000;
	localparam longint POLL_CYCLES = (CLOCK_HZ * POLL_PERIOD_MS) / 1000;
	localparam int STORE_INTERVAL_S = 60;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] temperature; // Signed, 0.1 degree
		logic [15:0] voltage; // mV
		logic [15:0] current; // Signed mA, negative in discharge
	} ltlog_reading_type;

	typedef struct packed {
		logic [15:0] temp_high;
		logic [15:0] temp_low;
		logic [15:0] volt_high;
		logic [15:0] volt_low;
		logic [15:0] chg_peak;
		logic [15:0] dsg_peak;
	} ltlog_records_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EVAL = 3'b010,
		ST_STORE = 3'b100
	} ltlog_state_type;

endpackage : ltlog_pkg

//--- sim/ltlog_chk.sv
`timescale 1ns/1ps
module ltlog_chk
	import ltlog_pkg::*;
#(
	parameter longint POLL_CYCLES_P = POLL_CYCLES // Poll period in clocks
) (
	input wire logic clk, // Clock
	input wire logic reset_n, // Async reset, active low
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Bus strobe
	input wire logic wb_we_i, // Bus write
	input wire logic [7:0] wb_adr_i, // Bus address
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Acknowledge
	input wire logic reading_valid, // Sample strobe
	input wire logic store_request // Store pulse
);
	// Ticks run free, so one tick of slack on the store spacing
	localparam longint GAP_MIN = 59 * POLL_CYCLES_P;
	logic [31:0] gap;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// Cycles since the last store, saturating
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gap <= '1;
		end else if (store_request) begin
			gap <= '0;
		end else if (gap != '1) begin
			gap <= gap + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	a_ack_after_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("no ack one cycle after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
		else $error("ack without request");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	a_fault_rsvd_zero: assert property (
		(wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == ADDR_FAULT) |-> wb_dat_o[31:6] == 26'h0)
		else $error("fault byte upper bits set");

	// ----------------------------------------------------------------
	// Record store
	// ----------------------------------------------------------------
	a_store_single: assert property (store_request |=> !store_request)
		else $error("store pulse longer than one cycle");
	a_store_cause: assert property (store_request |-> $past(reading_valid, 3))
		else $error("store without a sample three cycles before");
	a_store_gap: assert property (store_request |-> gap >= GAP_MIN)
		else $error("stores closer than the throttle");
endmodule : ltlog_chk

bind ltlog_top ltlog_chk #(.POLL_CYCLES_P(POLL_CYCLES_P)) chk (.clk, .reset_n, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .reading_valid, .store_request);

//--- sim/ltlog_front.sv
`timescale 1ns/1ps
module ltlog_front
	import ltlog_pkg::*;
(
	input wire logic clk, // Logger clock
	output ltlog_reading_type reading, // Measurement word
	output logic reading_valid, // One-cycle sample strobe
	output logic [5:0] protector_status // Protector fault pins
);
	// Idle front end, no faults
	initial begin
		reading = '0;
		reading_valid = 1'b0;
		protector_status = 6'h00;
	end

	// One strobe; the word then scrambles so stale data never looks valid
	task automatic send(input logic [15:0] t, input logic [15:0] v, input logic [15:0] c);
		@(posedge clk);
		reading <= {t, v, c};
		reading_valid <= 1'b1;
		@(posedge clk);
		reading_valid <= 1'b0;
		reading <= ~{t, v, c};
	endtask : send

	// Fault pins are levels, held until changed
	task automatic set_prot(input logic [5:0] p);
		@(posedge clk);
		protector_status <= p;
	endtask : set_prot
endmodule : ltlog_front

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import ltlog_pkg::*;
;
	logic clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [7:0] acc;
	logic [31:0] wdat = 32'h0, rdat;
	logic [32:0] ent;
	logic ack, store_request, irq, reading_valid;
	logic [5:0] prot;
	ltlog_reading_type reading;
	logic [32:0] exp_q[$];
	bit st_q[$];
	int n_fail = 0, compares = 0;
	localparam logic [7:0] RA[12] = '{ADDR_TEMP_HIGH, ADDR_TEMP_LOW, ADDR_VOLT_HIGH,
		ADDR_VOLT_LOW, ADDR_CHG_PEAK, ADDR_DSG_PEAK, ADDR_TEMP_STEP, ADDR_VOLT_STEP,
		ADDR_CUR_STEP, ADDR_WRITE_CNT, ADDR_FAULT, 8'h3C};
	localparam logic [15:0] RV[12] = '{RST_TEMP_HIGH, RST_TEMP_LOW, RST_VOLT_HIGH,
		RST_VOLT_LOW, RST_CHG_PEAK, RST_DSG_PEAK, 16'h000A, 16'h0019, 16'h0064, 16'h0000,
		16'h0000, 16'h0000};

	// 25 MHz clock
	initial forever #20 clk = ~clk;

	ltlog_top #(.POLL_CYCLES_P(50)) dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .reading(reading), .reading_valid(reading_valid),
		.protector_status(prot), .store_request(store_request), .irq(irq));
	ltlog_front fe (.clk(clk), .reading(reading), .reading_valid(reading_valid),
		.protector_status(prot));

	// ----------------------------------------------------------------
	// Compare and bus tasks
	// ----------------------------------------------------------------
	task automatic cmp_dat(input logic [31:0] got, input logic [31:0] e);
		compares++;
		if (got !== e) begin
			n_fail++;
			$display("mismatch t=%0t read %h expected %h", $time, got, e);
		end
	endtask : cmp_dat
	task automatic cmp_lvl(input logic got, input logic e);
		compares++;
		if (got !== e) begin
			n_fail++;
			$display("mismatch t=%0t level %b expected %b", $time, got, e);
		end
	endtask : cmp_lvl
	// Request held until ack is sampled, released only at that edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
		@(posedge clk);
		exp_q.push_back({c, d});
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 1'b0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, e, 1'b1);
	endtask : rd
	// Six records read in register order
	task automatic rec(input ltlog_records_type r);
		for (int i = 0; i < 6; i++) rd(ADDR_TEMP_HIGH + 8'(4 * i), {16'h0, r[95 - 16 * i -: 16]});
	endtask : rec
	task automatic print_verdict;
		$display("n_fail=%0d compares=%0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : print_verdict

	// Monitor: oldest note against each ack and each store pulse
	always @(posedge clk) begin
		if (ack === 1'b1) begin
			ent = exp_q.pop_front();
			if (ent[32]) cmp_dat(rdat, ent[31:0]);
		end
		if (store_request === 1'b1) begin
			cmp_lvl(st_q.size() > 0, 1'b1);
			if (st_q.size() > 0) void'(st_q.pop_front());
		end
	end

	// Watchdog, well beyond the expected run
	initial begin
		#400000;
		n_fail++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(95));
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		foreach (RA[i]) rd(RA[i], {16'h0, RV[i]});
		// Gauging off: sample ignored
		fe.send(16'd900, 16'd2900, 16'd0);
		repeat (6) @(posedge clk);
		rd(ADDR_TEMP_HIGH, 32'h0);
		wr(ADDR_CONTROL, 32'h1);
		wr(ADDR_IRQ_ENABLE, 32'h3);
		// Temperatures and low voltage qualify; high voltage and discharge only merely better
		st_q.push_back(1'b1);
		fe.send(16'd300, 16'd2810, -16'sd50);
		repeat (6) @(posedge clk);
		rec({16'd300, 16'd300, 16'd2810, 16'd2810, 16'h0, 16'hFFCE});
		rd(ADDR_WRITE_CNT, 32'h1);
		cmp_lvl(irq, 1'b1);
		wr(ADDR_IRQ_CLEAR, 32'h1);
		repeat (2) @(posedge clk);
		cmp_lvl(irq, 1'b0);
		// Throttled sample dropped
		fe.send(16'd600, 16'd2810, -16'sd50);
		repeat (6) @(posedge clk);
		rd(ADDR_TEMP_HIGH, 32'd300);
		repeat (3100) @(posedge clk);
		// Exactly one step above is not enough on its own
		fe.send(16'd310, 16'd2810, 16'd0);
		repeat (6) @(posedge clk);
		rd(ADDR_TEMP_HIGH, 32'd300);
		// Store interrupt masked; charge qualifies, high temperature and low voltage join
		wr(ADDR_IRQ_ENABLE, 32'h2);
		st_q.push_back(1'b1);
		fe.send(16'd310, 16'd2805, 16'sd150);
		repeat (6) @(posedge clk);
		rec({16'd310, 16'd300, 16'd2810, 16'd2805, 16'd150, 16'hFFCE});
		rd(ADDR_WRITE_CNT, 32'h2);
		rd(ADDR_IRQ_STATUS, 32'h1);
		cmp_lvl(irq, 1'b0);
		acc = 8'($urandom);
		wr(ADDR_TEMP_STEP, {24'h0, acc});
		rd(ADDR_TEMP_STEP, {24'h0, acc});
		// Faults: random pattern, then each pin alone
		wr(ADDR_IRQ_CLEAR, 32'h3);
		acc = 8'($urandom_range(1, 63));
		fe.set_prot(acc[5:0]);
		repeat (120) @(posedge clk);
		rd(ADDR_FAULT, {24'h0, acc});
		cmp_lvl(irq, 1'b1);
		for (int i = 0; i < 6; i++) begin
			fe.set_prot(6'(1 << i));
			acc[i] = 1'b1;
			repeat (120) @(posedge clk);
			rd(ADDR_FAULT, {24'h0, acc});
		end
		fe.set_prot(6'h00);
		wr(ADDR_IRQ_CLEAR, 32'h2);
		repeat (120) @(posedge clk);
		cmp_lvl(irq, 1'b0);
		rd(ADDR_FAULT, 32'h3F);
		cmp_lvl(st_q.size() == 0, 1'b1);
		print_verdict();
	end
endmodule : tb_top
